/* File: mpw_top.sv */
// Memory paging window mapper: page index registers and registered translation.
// Assumes the core writes page indices through dedicated load strobes.
`timescale 1ns/10ps
module mpw_top
(
   input wire logic clk_i,                               // Bus clock
   input wire logic rst_n_i,                             // Async reset, active low
   input wire logic prog_pg_we_i,                        // Load program page index
   input wire logic ram_pg_we_i,                         // Load RAM page index
   input wire logic eee_pg_we_i,                         // Load EEPROM page index
   input wire logic glob_pg_we_i,                        // Load global page index
   input wire logic [mpw_pkg::PAGE_W-1:0] page_wdata_i,  // Page value
   input wire logic req_i,                               // Access request
   input wire logic global_i,                            // Access is global
   input wire logic [mpw_pkg::LOCAL_W-1:0] addr_i,       // Local address
   output logic gvalid_o,                                // Translated access valid
   output logic [mpw_pkg::GLOBAL_W-1:0] gaddr_o,         // Global address
   output logic [3:0] win_o,                             // One-hot window used
   output logic [mpw_pkg::PAGE_W-1:0] program_page_index_o, // Program page index
   output logic [mpw_pkg::PAGE_W-1:0] ram_page_index_o,  // RAM page index
   output logic [mpw_pkg::PAGE_W-1:0] eee_page_index_o,  // EEPROM page index
   output logic [mpw_pkg::GLOB_PG_W-1:0] global_page_index_o // Global page index
);
   import mpw_pkg::*;

   logic [PAGE_W-1:0] prog_pg_r;
   logic [PAGE_W-1:0] ram_pg_r;
   logic [PAGE_W-1:0] eee_pg_r;
   logic [GLOB_PG_W-1:0] glob_pg_r;
   logic [PAGE_W-1:0] prog_pg_nxt;
   logic [GLOBAL_W-1:0] gaddr_nxt;
   logic hit_nxt;
   mpw_win_t win_nxt;
   mpw_if pg ();

   // A page load in the same cycle as a flash access is seen by that access.
   assign prog_pg_nxt = prog_pg_we_i ? page_wdata_i : prog_pg_r;
   assign pg.program_page_index = prog_pg_nxt;
   assign pg.ram_page_index = ram_pg_we_i ? page_wdata_i : ram_pg_r;
   assign pg.eee_page_index = eee_pg_we_i ? page_wdata_i : eee_pg_r;
   assign pg.global_page_index = glob_pg_we_i ? page_wdata_i[GLOB_PG_W-1:0] : glob_pg_r;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         prog_pg_r <= PROG_PG_RST;
         ram_pg_r <= RAM_PG_RST;
         eee_pg_r <= EEE_PG_RST;
         glob_pg_r <= GLOB_PG_RST;
      end
      else
      begin
         prog_pg_r <= prog_pg_nxt;
         if (ram_pg_we_i)
            ram_pg_r <= page_wdata_i;
         if (eee_pg_we_i)
            eee_pg_r <= page_wdata_i;
         if (glob_pg_we_i)
            glob_pg_r <= page_wdata_i[GLOB_PG_W-1:0];
      end
   end

   mpw_xlate u_xlate
   (
      .pg(pg),
      .addr_i(addr_i),
      .global_i(global_i),
      .gaddr_o(gaddr_nxt),
      .hit_o(hit_nxt),
      .win_o(win_nxt)
   );

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         gvalid_o <= 1'b0;
         gaddr_o <= '0;
         win_o <= MPW_WIN_NONE;
      end
      else
      begin
         gvalid_o <= req_i & hit_nxt;
         if (req_i)
         begin
            gaddr_o <= gaddr_nxt;
            win_o <= win_nxt;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         program_page_index_o <= PROG_PG_RST;
         ram_page_index_o <= RAM_PG_RST;
         eee_page_index_o <= EEE_PG_RST;
         global_page_index_o <= GLOB_PG_RST;
      end
      else
      begin
         program_page_index_o <= prog_pg_nxt;
         ram_page_index_o <= pg.ram_page_index;
         eee_page_index_o <= pg.eee_page_index;
         global_page_index_o <= pg.global_page_index;
      end
   end
endmodule

/* File: mpw_pkg.sv */
// Constants and types of the memory paging window mapper.
// Assumes a single bus clock domain; no software-visible registers of its own.
// Operation
// - Local addresses 0x8000 to 0xBFFF show the 16 KB flash page chosen by the program page index.
// - Local addresses 0x1000 to 0x1FFF show the 4 KB RAM page chosen by the RAM page index.
// - Local addresses 0x0800 to 0x0BFF show the 1 KB EEPROM page chosen by the EEPROM page index.
// - Global addresses are 23 bits wide and span 0x000000 to 0x7fffff, one place per resource.
// - A global access uses the global page index and bypasses the local windows entirely.
// - Pages that also sit at fixed local addresses stay reachable through the windows.
// - A new program page index takes effect on the very next window access.
package mpw_pkg;
   localparam int LOCAL_W = 16;
   localparam int GLOBAL_W = 23;
   localparam int PAGE_W = 8;
   localparam int GLOB_PG_W = 7;
   localparam int FLASH_OFS_W = 14;
   localparam int RAM_OFS_W = 12;
   localparam int EEE_OFS_W = 10;
   localparam logic [LOCAL_W-1:0] FLASH_LO = 16'h8000;
   localparam logic [LOCAL_W-1:0] FLASH_HI = 16'hbfff;
   localparam logic [LOCAL_W-1:0] RAM_LO = 16'h1000;
   localparam logic [LOCAL_W-1:0] RAM_HI = 16'h1fff;
   localparam logic [LOCAL_W-1:0] EEE_LO = 16'h0800;
   localparam logic [LOCAL_W-1:0] EEE_HI = 16'h0bff;
   // Global bases of each resource class; the page index fills the bits above the offset.
   localparam logic [GLOBAL_W-1:0] FLASH_BASE = 23'h400000;
   localparam logic [GLOBAL_W-1:0] RAM_BASE = 23'h000000;
   localparam logic [GLOBAL_W-1:0] EEE_BASE = 23'h100000;
   localparam logic [PAGE_W-1:0] PROG_PG_RST = 8'hfe;
   localparam logic [PAGE_W-1:0] RAM_PG_RST = 8'hfd;
   localparam logic [PAGE_W-1:0] EEE_PG_RST = 8'hfe;
   localparam logic [GLOB_PG_W-1:0] GLOB_PG_RST = 7'h00;
   typedef enum logic [3:0]
   {
      MPW_WIN_NONE  = 4'b0001,
      MPW_WIN_EEE   = 4'b0010,
      MPW_WIN_RAM   = 4'b0100,
      MPW_WIN_FLASH = 4'b1000
   } mpw_win_t;
endpackage

/* File: mpw_if.sv */
// Interface carrying the page indices from the mapper top to its translator.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
interface mpw_if;
   import mpw_pkg::*;
   logic [PAGE_W-1:0] program_page_index;
   logic [PAGE_W-1:0] ram_page_index;
   logic [PAGE_W-1:0] eee_page_index;
   logic [GLOB_PG_W-1:0] global_page_index;
   modport src (output program_page_index, ram_page_index, eee_page_index, global_page_index);
   modport dst (input program_page_index, ram_page_index, eee_page_index, global_page_index);
endinterface

/* File: mpw_xlate.sv */
// Combinational translation of a local or global access into a global address.
// Assumes page indices come from registers on the same clock, or from the load data when a load strobe is set.
`timescale 1ns/10ps
module mpw_xlate
   import mpw_pkg::*;
(
   mpw_if.dst pg,                              // Page indices
   input wire logic [LOCAL_W-1:0] addr_i,      // Local address
   input wire logic global_i,                  // Global access
   output logic [GLOBAL_W-1:0] gaddr_o,        // Global address
   output logic hit_o,                         // Access maps somewhere
   output mpw_win_t win_o                      // Window used
);
   logic [GLOBAL_W-1:0] fl_a;
   logic [GLOBAL_W-1:0] rm_a;
   logic [GLOBAL_W-1:0] ee_a;

   // Every page index bit lands below its base, so the whole index reaches the global address.
   assign fl_a = FLASH_BASE | GLOBAL_W'({pg.program_page_index, addr_i[FLASH_OFS_W-1:0]});
   assign rm_a = RAM_BASE | GLOBAL_W'({pg.ram_page_index, addr_i[RAM_OFS_W-1:0]});
   assign ee_a = EEE_BASE | GLOBAL_W'({pg.eee_page_index, addr_i[EEE_OFS_W-1:0]});

   always_comb
   begin
      gaddr_o = '0;
      hit_o = 1'b0;
      win_o = MPW_WIN_NONE;
      if (global_i)
      begin
         gaddr_o = {pg.global_page_index, addr_i};
         hit_o = 1'b1;
      end
      else if (addr_i >= FLASH_LO && addr_i <= FLASH_HI)
      begin
         gaddr_o = fl_a;
         hit_o = 1'b1;
         win_o = MPW_WIN_FLASH;
      end
      else if (addr_i >= RAM_LO && addr_i <= RAM_HI)
      begin
         gaddr_o = rm_a;
         hit_o = 1'b1;
         win_o = MPW_WIN_RAM;
      end
      else if (addr_i >= EEE_LO && addr_i <= EEE_HI)
      begin
         gaddr_o = ee_a;
         hit_o = 1'b1;
         win_o = MPW_WIN_EEE;
      end
   end
endmodule

/* File: mpw_chk.sv */
// Port assertions of the paging window mapper.
// Bound into mpw_top; one clock, asynchronous active-low reset.
`timescale 1ns/10ps
module mpw_chk
   import mpw_pkg::*;
(
   input wire logic clk_i, // Clock
   input wire logic rst_n_i, // Reset
   input wire logic prog_pg_we_i, // Load
   input wire logic ram_pg_we_i, // Load
   input wire logic eee_pg_we_i, // Load
   input wire logic glob_pg_we_i, // Load
   input wire logic [7:0] page_wdata_i, // Value
   input wire logic req_i, // Request
   input wire logic global_i, // Global
   input wire logic [15:0] addr_i, // Address
   input wire logic gvalid_o, // Valid
   input wire logic [22:0] gaddr_o, // Result
   input wire logic [3:0] win_o, // Window
   input wire logic [7:0] program_page_index_o, // Index
   input wire logic [7:0] ram_page_index_o, // Index
   input wire logic [7:0] eee_page_index_o, // Index
   input wire logic [6:0] global_page_index_o // Index
);
   logic [7:0] pp;
   logic [7:0] rp;
   logic [7:0] ep;
   logic [6:0] gp;
   logic fl, rm, ee;
   assign pp = prog_pg_we_i ? page_wdata_i : program_page_index_o;
   assign rp = ram_pg_we_i ? page_wdata_i : ram_page_index_o;
   assign ep = eee_pg_we_i ? page_wdata_i : eee_page_index_o;
   assign gp = glob_pg_we_i ? page_wdata_i[6:0] : global_page_index_o;
   assign fl = addr_i >= FLASH_LO && addr_i <= FLASH_HI;
   assign rm = addr_i >= RAM_LO && addr_i <= RAM_HI;
   assign ee = addr_i >= EEE_LO && addr_i <= EEE_HI;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   sequence s_loc(hit);
      req_i && !global_i && hit;
   endsequence
   a_flash_map: assert property (s_loc(fl) |=> gvalid_o && win_o == 4'h8 &&
      gaddr_o == (FLASH_BASE | {$past(pp), $past(addr_i[13:0])})) else $error("flash map");
   a_ram_map: assert property (s_loc(rm) |=> gvalid_o && win_o == 4'h4 &&
      gaddr_o == (RAM_BASE | {$past(rp), $past(addr_i[11:0])})) else $error("ram map");
   a_eee_map: assert property (s_loc(ee) |=> gvalid_o && win_o == 4'h2 &&
      gaddr_o == (EEE_BASE | {$past(ep), $past(addr_i[9:0])})) else $error("eeprom map");
   a_global_map: assert property (req_i && global_i |=> gvalid_o && win_o == 4'h1 &&
      gaddr_o == {$past(gp), $past(addr_i)}) else $error("global map");
   a_unmapped_none: assert property (s_loc(!(fl || rm || ee)) |=>
      !gvalid_o && gaddr_o == 23'h0 && win_o == 4'h1) else $error("unmapped");
   a_idle_hold: assert property (!req_i |=> !gvalid_o && $stable(gaddr_o))
      else $error("idle hold");
   a_prog_load: assert property (prog_pg_we_i |=> program_page_index_o == $past(page_wdata_i))
      else $error("page load");
   a_glob_keep: assert property (!glob_pg_we_i |=> $stable(global_page_index_o))
      else $error("global page");
endmodule
bind mpw_top mpw_chk u_chk (.*);

/* File: mpw_core_mdl.sv */
// Processor core model issuing one local or global access per call.
// Caller sits just after a rising edge; signals change by non-blocking assignment.
`timescale 1ns/10ps
module mpw_core_mdl
(
   output logic req_o = 1'b0, // Request
   output logic global_o = 1'b0, // Global
   output logic [15:0] addr_o = 16'h0 // Address
);
   task automatic access(input logic g, input logic [15:0] a);
      req_o <= 1'b1;
      global_o <= g;
      addr_o <= a;
   endtask
   // Released lines flip so that no stale address looks valid.
   task automatic idle();
      req_o <= 1'b0;
      global_o <= ~global_o;
      addr_o <= ~addr_o;
   endtask
endmodule

/* File: tb_top.sv */
// Self-checking testbench of the paging window mapper.
// Core model drives accesses; the bench loads page indices.
`timescale 1ns/10ps
module tb_top;
   logic clk_i = 1'b0, rst_n_i = 1'b0, req_i, global_i, gvalid_o;
   logic prog_pg_we_i = 1'b0, ram_pg_we_i = 1'b0, eee_pg_we_i = 1'b0, glob_pg_we_i = 1'b0;
   logic [7:0] page_wdata_i = 8'h0, pp = 8'hfe, rp = 8'hfd, ep = 8'hfe;
   logic [7:0] program_page_index_o, ram_page_index_o, eee_page_index_o;
   logic [6:0] global_page_index_o, gp = 7'h0;
   logic [15:0] addr_i, r;
   logic [22:0] gaddr_o;
   logic [3:0] win_o;
   int fail_count = 0, compares = 0;
   always #5 clk_i = ~clk_i;
   mpw_top u_dut (.*);
   mpw_core_mdl u_core (.req_o(req_i), .global_o(global_i), .addr_o(addr_i));
   function automatic logic [27:0] exp_f(input logic g, input logic [15:0] a);
      if (g) return {5'h11, gp, a};
      if (a[15:14] == 2'b10) return {5'h18, 1'b1, pp, a[13:0]};
      if (a[15:12] == 4'h1) return {5'h14, 3'h0, rp, a[11:0]};
      if (a[15:10] == 6'h02) return {5'h12, 5'h04, ep, a[9:0]};
      return {5'h01, 23'h0};
   endfunction
   task automatic chk(input logic [30:0] got, input logic [30:0] exp);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic op(input int ld, input logic [7:0] d, input logic g, input logic [15:0] a);
      logic [27:0] e;
      @(posedge clk_i);
      {glob_pg_we_i, eee_pg_we_i, ram_pg_we_i, prog_pg_we_i} <= 4'(32'h1 << ld >> 1);
      page_wdata_i <= d;
      case (ld)
         1: pp = d;
         2: rp = d;
         3: ep = d;
         4: gp = d[6:0];
         default: ;
      endcase
      e = exp_f(g, a);
      u_core.access(g, a);
      @(posedge clk_i);
      {glob_pg_we_i, eee_pg_we_i, ram_pg_we_i, prog_pg_we_i} <= 4'h0;
      u_core.idle();
      #1;
      chk({3'h0, gvalid_o, win_o, gaddr_o}, {3'h0, e});
      chk({program_page_index_o, ram_page_index_o, eee_page_index_o, global_page_index_o},
         {pp, rp, ep, gp});
   endtask
   initial
   begin
      r = 16'($urandom(32'h121484d0));
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      op(1, 8'hfc, 1'b0, 16'h8000);
      op(2, 8'hff, 1'b0, 16'h1fff);
      op(3, 8'hfd, 1'b0, 16'h0bff);
      op(4, 8'hff, 1'b1, 16'hffff);
      op(0, 8'h0, 1'b0, 16'h0c00);
      op(0, 8'h0, 1'b0, 16'hc000);
      op(1, 8'hfe, 1'b1, 16'h8000);
      $display("corner tests done");
      // Reset in mid-run must bring every output back to its reset value.
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      @(posedge clk_i);
      #1;
      pp = mpw_pkg::PROG_PG_RST;
      rp = mpw_pkg::RAM_PG_RST;
      ep = mpw_pkg::EEE_PG_RST;
      gp = mpw_pkg::GLOB_PG_RST;
      chk({3'h0, gvalid_o, win_o, gaddr_o}, {3'h0, 5'h01, 23'h0});
      chk({program_page_index_o, ram_page_index_o, eee_page_index_o, global_page_index_o},
         {pp, rp, ep, gp});
      @(posedge clk_i);
      rst_n_i <= 1'b1;
      $display("reset test done");
      repeat (400)
      begin
         r = 16'($urandom);
         case ($urandom % 4)
            0: r[15:14] = 2'b10;
            1: r[15:12] = 4'h1;
            2: r[15:10] = 6'h02;
            default: ;
         endcase
         op($urandom % 5, 8'($urandom), ($urandom % 5) == 0, r);
      end
      $display("random tests done");
      tally_and_finish();
   end
   initial
   begin
      repeat (5000) @(posedge clk_i);
      fail_count++;
      tally_and_finish();
   end
endmodule
